// ==== pkg/wfpf_regs.svh ====
// Register offsets, field positions and reset values of the pattern filter.
`ifndef WFPF_REGS_SVH
`define WFPF_REGS_SVH

`define WFPF_OFS_WCS       6'h00
`define WFPF_OFS_CFGA      6'h04
`define WFPF_OFS_CFGB      6'h08
`define WFPF_OFS_MASK0     6'h0c
`define WFPF_OFS_MASK1     6'h10
`define WFPF_OFS_MASK2     6'h14
`define WFPF_OFS_MASK3     6'h18
`define WFPF_OFS_ADDRA     6'h1c
`define WFPF_OFS_ADDRB     6'h20
`define WFPF_OFS_ADDRC     6'h24
`define WFPF_OFS_IRQ_MASK  6'h28
`define WFPF_OFS_IRQ_FLAGS 6'h2c

`define WFPF_WCS_EN        0
`define WFPF_WCS_RCV       1
`define WFPF_WCS_CFGD      2
`define WFPF_CFGA_FEN      0
`define WFPF_CFGA_AME      1
`define WFPF_CFGA_AMC      2
`define WFPF_CFGA_BCE      3
`define WFPF_CFGA_TRG      4
`define WFPF_CFGA_OFS_LSB  8
`define WFPF_IRQ_WOL       8

`define WFPF_CRC_PRESET    16'hffff
`define WFPF_CRC_RST       16'h0000
`define WFPF_MASK_BYTES    9'h080
`define WFPF_DA_BYTES      9'h006
`define WFPF_POS_MAX       9'h1ff

`endif

// ==== pkg/wfpf_pkg.sv ====
// Types shared by the pattern filter modules.
package wfpf_pkg;

   typedef enum logic [1:0]
   {
      WFPF_IDLE  = 2'b00,
      WFPF_RECV  = 2'b01,
      WFPF_CHECK = 2'b11
   } wfpf_state_t;

   typedef logic [15:0] wfpf_crc_t;

endpackage

// ==== core/wfpf_crc16.sv ====
// One byte step of the wake pattern CRC-16.
`timescale 1ns/1ps
module wfpf_crc16
   import wfpf_pkg::*;
(
   // Accumulator and byte.
   input  wire wfpf_crc_t   crc_in,
   input  wire logic [7:0]  data,
   // Updated accumulator.
   output wfpf_crc_t        crc_out
);

   logic [7:0] f;

   // Intermediate terms chain through the data bits.
   always_comb
   begin
      f[0] = crc_in[15] ^ data[0];
      for (int i = 1; i < 8; i++)
      begin
         f[i] = crc_in[15 - i] ^ f[i - 1] ^ data[i];
      end
   end

   assign crc_out = {crc_in[7] ^ f[7], crc_in[6:2], crc_in[1] ^ f[0],
                     crc_in[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3],
                     f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7],
                     f[6], f[7]};

endmodule

// ==== core/wfpf_filter.sv ====
// Wake pattern filter with its register file on an Avalon-MM slave.
`timescale 1ns/1ps
`include "wfpf_regs.svh"
module wfpf_filter
   import wfpf_pkg::*;
(
   // Clock and resets.
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        soft_rst,
   // Received frame bytes.
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_sof,
   input  wire logic        rx_eof,
   input  wire logic        rx_fcs_ok,
   input  wire logic        rx_len_ok,
   // Register bus.
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Wake indication.
   output logic             wake_event,
   output logic             wol_event_flag
);

   // Merges written bytes into a register value.
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Saturating byte position increment.
   function automatic logic [8:0] sat_inc(input logic [8:0] p);
      return (p == `WFPF_POS_MAX) ? p : p + 9'h001;
   endfunction

   // Bus slave state.
   logic        ack_r;
   logic [31:0] rdata_r;
   // Configuration and status.
   logic        det_en_r;
   logic        cfgd_r;
   logic        rcv_r;
   logic [15:0] cfga_r;
   logic        trg_r;
   logic [15:0] exp_crc_r;
   logic [127:0] mask_r;
   logic [15:0] addr_a_r;
   logic [15:0] addr_b_r;
   logic [15:0] addr_c_r;
   logic        irq_mask_r;
   logic        wol_r;
   // Frame path.
   wfpf_state_t state_r;
   wfpf_state_t state_nxt;
   logic [8:0]  pos_r;
   wfpf_crc_t   crc_r;
   wfpf_crc_t   crc_nxt;
   logic [47:0] da_r;
   logic        ok_r;
   logic        wake_r;

   // Bus decoding.
   wire req     = avs_read | avs_write;
   wire wr_go   = avs_write & ack_r;
   wire sel_wcs = avs_address == `WFPF_OFS_WCS;
   wire sel_cfa = avs_address == `WFPF_OFS_CFGA;
   wire sel_cfb = avs_address == `WFPF_OFS_CFGB;
   wire sel_m0  = avs_address == `WFPF_OFS_MASK0;
   wire sel_m1  = avs_address == `WFPF_OFS_MASK1;
   wire sel_m2  = avs_address == `WFPF_OFS_MASK2;
   wire sel_m3  = avs_address == `WFPF_OFS_MASK3;
   wire sel_aa  = avs_address == `WFPF_OFS_ADDRA;
   wire sel_ab  = avs_address == `WFPF_OFS_ADDRB;
   wire sel_ac  = avs_address == `WFPF_OFS_ADDRC;
   wire sel_im  = avs_address == `WFPF_OFS_IRQ_MASK;
   wire sel_if  = avs_address == `WFPF_OFS_IRQ_FLAGS;
   wire [31:0] wd_low = avs_writedata & {32{avs_byteenable[0]}};
   wire [31:0] wd_hi1 = avs_writedata & {32{avs_byteenable[1]}};
   wire clr_rcv = wr_go & sel_wcs & wd_low[`WFPF_WCS_RCV];
   wire clr_trg = wr_go & sel_cfa & wd_low[`WFPF_CFGA_TRG];
   wire clr_wol = wr_go & sel_if & wd_hi1[`WFPF_IRQ_WOL];

   // Configuration fields.
   wire       f_en   = cfga_r[`WFPF_CFGA_FEN];
   wire       am_en  = cfga_r[`WFPF_CFGA_AME];
   wire       amc_en = cfga_r[`WFPF_CFGA_AMC];
   wire       bc_en  = cfga_r[`WFPF_CFGA_BCE];
   wire [7:0] offs   = cfga_r[`WFPF_CFGA_OFS_LSB +: 8];
   wire       det_on = det_en_r & f_en;

   // Read data selection.
   wire [31:0] rd_wcs = {29'h0, cfgd_r, rcv_r, det_en_r};
   wire [31:0] rd_cfa = {16'h0, cfga_r[15:5], trg_r, cfga_r[3:0]};
   wire [31:0] rd_mux =
      sel_wcs ? rd_wcs :
      sel_cfa ? rd_cfa :
      sel_cfb ? {16'h0, exp_crc_r} :
      sel_m0  ? mask_r[31:0] :
      sel_m1  ? mask_r[63:32] :
      sel_m2  ? mask_r[95:64] :
      sel_m3  ? mask_r[127:96] :
      sel_aa  ? {16'h0, addr_a_r} :
      sel_ab  ? {16'h0, addr_b_r} :
      sel_ac  ? {16'h0, addr_c_r} :
      sel_im  ? {23'h0, irq_mask_r, 8'h0} :
      sel_if  ? {23'h0, wol_r, 8'h0} : 32'h0;

   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata    = rdata_r;

   // One wait cycle, then the answer.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0;
      end
      else
      begin
         ack_r <= req & ~ack_r;
         if (avs_read & ~ack_r)
         begin
            rdata_r <= rd_mux;
         end
      end
   end

   // Configuration registers ignore the soft reset.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         det_en_r   <= 1'b0;
         cfgd_r     <= 1'b0;
         cfga_r     <= 16'h0;
         exp_crc_r  <= `WFPF_CRC_RST;
         mask_r     <= 128'h0;
         addr_a_r   <= 16'h0;
         addr_b_r   <= 16'h0;
         addr_c_r   <= 16'h0;
         irq_mask_r <= 1'b0;
      end
      else if (wr_go)
      begin
         if (sel_wcs & avs_byteenable[0])
         begin
            det_en_r <= avs_writedata[`WFPF_WCS_EN];
            cfgd_r   <= avs_writedata[`WFPF_WCS_CFGD];
         end
         if (sel_cfa)
         begin
            cfga_r <= 16'(be_merge({16'h0, cfga_r}, avs_writedata,
                                   avs_byteenable));
         end
         if (sel_cfb)
         begin
            exp_crc_r <= 16'(be_merge({16'h0, exp_crc_r}, avs_writedata,
                                      avs_byteenable));
         end
         if (sel_m0)
         begin
            mask_r[31:0] <= be_merge(mask_r[31:0], avs_writedata,
                                     avs_byteenable);
         end
         if (sel_m1)
         begin
            mask_r[63:32] <= be_merge(mask_r[63:32], avs_writedata,
                                      avs_byteenable);
         end
         if (sel_m2)
         begin
            mask_r[95:64] <= be_merge(mask_r[95:64], avs_writedata,
                                      avs_byteenable);
         end
         if (sel_m3)
         begin
            mask_r[127:96] <= be_merge(mask_r[127:96], avs_writedata,
                                       avs_byteenable);
         end
         if (sel_aa)
         begin
            addr_a_r <= 16'(be_merge({16'h0, addr_a_r}, avs_writedata,
                                     avs_byteenable));
         end
         if (sel_ab)
         begin
            addr_b_r <= 16'(be_merge({16'h0, addr_b_r}, avs_writedata,
                                     avs_byteenable));
         end
         if (sel_ac)
         begin
            addr_c_r <= 16'(be_merge({16'h0, addr_c_r}, avs_writedata,
                                     avs_byteenable));
         end
         if (sel_im & avs_byteenable[1])
         begin
            irq_mask_r <= avs_writedata[`WFPF_IRQ_WOL];
         end
      end
   end

   // Byte selection and CRC accumulation.
   wire        in_frame = state_r == WFPF_RECV;
   wire        start    = rx_valid & rx_sof & det_on;
   wire        byte_go  = rx_valid & (start | (in_frame & ~rx_sof));
   wire [8:0]  pos_cur  = rx_sof ? 9'h000 : pos_r;
   wire [8:0]  rel      = pos_cur - {1'b0, offs};
   wire        in_win   = (pos_cur >= {1'b0, offs}) & (rel < `WFPF_MASK_BYTES);
   wire        incl     = byte_go & in_win & mask_r[rel[6:0]];
   wire [15:0] crc_base = rx_sof ? `WFPF_CRC_PRESET : crc_r;
   wire [15:0] crc_step;

   wfpf_crc16 u_crc
   (
      .crc_in  (crc_base),
      .data    (rx_data),
      .crc_out (crc_step)
   );

   always_comb
   begin
      crc_nxt = crc_r;
      if (byte_go)
      begin
         crc_nxt = incl ? crc_step : crc_base;
      end
   end

   // Frame sequencing; a new start aborts an unfinished frame.
   always_comb
   begin
      case (state_r)
         WFPF_IDLE:
            state_nxt = start ? WFPF_RECV : WFPF_IDLE;
         WFPF_RECV:
            state_nxt = (byte_go & rx_eof) ? WFPF_CHECK :
                        (rx_valid & rx_sof & ~det_on) ? WFPF_IDLE : WFPF_RECV;
         WFPF_CHECK:
            state_nxt = start ? WFPF_RECV : WFPF_IDLE;
         default:
            state_nxt = WFPF_IDLE;
      endcase
      if (start & rx_eof)
      begin
         state_nxt = WFPF_CHECK;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= WFPF_IDLE;
         pos_r   <= 9'h000;
         crc_r   <= `WFPF_CRC_PRESET;
         da_r    <= 48'h0;
         ok_r    <= 1'b0;
      end
      else if (soft_rst)
      begin
         state_r <= WFPF_IDLE;
         pos_r   <= 9'h000;
      end
      else
      begin
         state_r <= state_nxt;
         crc_r   <= crc_nxt;
         if (byte_go)
         begin
            pos_r <= sat_inc(pos_cur);
            if (pos_cur < `WFPF_DA_BYTES)
            begin
               da_r[{pos_cur[2:0], 3'b000} +: 8] <= rx_data;
            end
            if (rx_eof)
            begin
               ok_r <= rx_fcs_ok & rx_len_ok & (pos_cur >= 9'h005);
            end
         end
      end
   end

   // Destination classification and wake decision.
   wire is_bc   = &da_r;
   wire is_mc   = ~is_bc & da_r[0];
   wire a_hit   = da_r == {addr_c_r, addr_b_r, addr_a_r};
   wire q_uni   = ~am_en | a_hit;
   wire q_mc    = amc_en | (am_en & a_hit);
   wire a_qual  = is_bc ? bc_en : (is_mc ? q_mc : q_uni);
   wire crc_hit = crc_r == exp_crc_r;
   wire checking = state_r == WFPF_CHECK;
   wire wake_hit = checking & det_on & crc_hit & a_qual & ok_r;

   // Sticky flags and the wake pulse; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rcv_r  <= 1'b0;
         trg_r  <= 1'b0;
         wol_r  <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         rcv_r  <= wake_hit | (rcv_r & ~clr_rcv);
         trg_r  <= wake_hit | (trg_r & ~clr_trg);
         wol_r  <= wake_hit | (wol_r & ~clr_wol);
         wake_r <= wake_hit;
      end
   end

   assign wake_event     = wake_r;
   assign wol_event_flag = wol_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   crc_preset_a: assert property (start & ~incl |=> crc_r == 16'hffff)
      else $error("CRC not preset at frame start");
   crc_hold_a: assert property (byte_go & ~rx_sof & ~incl & ~soft_rst
      |=> $stable(crc_r))
      else $error("Excluded byte changed the CRC");
   wake_flags_a: assert property (wake_hit |=> rcv_r & trg_r & wol_r
      & wake_event)
      else $error("Wake flags not set after a match");
   trig_only_a: assert property ($rose(trg_r) |-> $past(wake_hit))
      else $error("Triggered flag rose without a match");
   wol_cause_a: assert property ($rose(wol_event_flag) |->
      $past(checking & crc_hit & ok_r))
      else $error("Wake event flag rose without a checked frame");
   fcs_gate_a: assert property (byte_go & rx_eof & ~(rx_fcs_ok & rx_len_ok)
      |-> ##2 ~wake_event)
      else $error("Wake on a frame that failed its checks");
   det_gate_a: assert property (~det_on |-> ##1 ~wake_event)
      else $error("Wake while detection disabled");
   bcast_class_a: assert property (checking & (da_r == 48'hffffffffffff)
      & ~bc_en |-> ~wake_hit)
      else $error("Broadcast woke with broadcast disabled");
   sticky_hold_a: assert property (wol_r & ~clr_wol |=> wol_r)
      else $error("Wake event flag dropped without a clear");
   bus_answer_a: assert property (avs_waitrequest |=> ~avs_waitrequest)
      else $error("Bus answer not given after one wait cycle");

   wake_seen_c: cover property (wake_hit);
   mcast_wake_c: cover property (wake_hit & is_mc);
   clear_race_c: cover property (wake_hit & clr_wol);
   read_done_c: cover property (avs_read & ~avs_waitrequest);

endmodule

// ==== dv/wfpf_frame_src.sv ====
// Frame source that plays received bytes into the pattern filter.
`timescale 1ns/1ps
module wfpf_frame_src
#(
   parameter int FLEN = 131
)
(
   // Clock and control.
   input  wire logic              clk,
   input  wire logic              go,
   input  wire logic [8*FLEN-1:0] frame_bits,
   input  wire logic              fcs_good,
   input  wire logic              len_good,
   // Byte stream.
   output logic                   rx_valid,
   output logic [7:0]             rx_data,
   output logic                   rx_sof,
   output logic                   rx_eof,
   output logic                   rx_fcs_ok,
   output logic                   rx_len_ok,
   output logic                   busy
);
   int p;
   initial
   begin
      {rx_valid, rx_sof, rx_eof, busy, rx_fcs_ok, rx_len_ok} = 6'h00;
      rx_data = 8'h00;
   end
   // Idle data and check lines toggle so that a stale value never looks like data.
   task automatic idle();
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_eof <= 1'b0;
      rx_data <= ~rx_data;
      rx_fcs_ok <= ~rx_fcs_ok;
      rx_len_ok <= ~rx_len_ok;
   endtask
   always
   begin
      @(posedge clk);
      if (go)
      begin
         busy <= 1'b1;
         for (p = 0; p < FLEN; p++)
         begin
            if (p == 7)
            begin
               idle();
               @(posedge clk);
            end
            rx_valid <= 1'b1;
            rx_sof <= (p == 0);
            rx_eof <= (p == FLEN - 1);
            rx_data <= frame_bits[8*p +: 8];
            rx_fcs_ok <= (p == FLEN - 1) ? fcs_good : ~rx_fcs_ok;
            rx_len_ok <= (p == FLEN - 1) ? len_good : ~rx_len_ok;
            @(posedge clk);
         end
         busy <= 1'b0;
      end
      idle();
   end
endmodule

// ==== dv/wfpf_filter_bench.sv ====
// Self-checking bench of the wake pattern filter.
`timescale 1ns/1ps
`include "wfpf_regs.svh"
module wfpf_filter_bench
   import wfpf_pkg::*;
;
   localparam int FLEN = 131;
   localparam logic [7:0] OFS = 8'h03;
   localparam logic [127:0] MASK = {32'h80000000, 32'h0, 32'h80000000,
                                    32'h000000f5};
   localparam logic [47:0] DA [4] = '{48'h554433221102, 48'h564433221102,
                                      48'h0900005e0001, 48'hffffffffffff};
   logic              clk, rst_b, soft_rst, go, fcs_good, len_good;
   logic              rx_valid, rx_sof, rx_eof, rx_fcs_ok, rx_len_ok, busy;
   logic [7:0]        rx_data;
   logic [5:0]        avs_address;
   logic              avs_read, avs_write, avs_waitrequest;
   logic [31:0]       avs_writedata, avs_readdata, rd;
   logic [3:0]        avs_byteenable;
   logic              wake_event, wol_event_flag;
   logic [8*FLEN-1:0] frame_bits;
   int                n_mismatch, n_checks, cycles;

   wfpf_filter DUT (.clk(clk), .rst_b(rst_b), .soft_rst(soft_rst),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
      .rx_eof(rx_eof), .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wake_event(wake_event),
      .wol_event_flag(wol_event_flag));
   wfpf_frame_src #(.FLEN(FLEN)) src (.clk(clk), .go(go),
      .frame_bits(frame_bits), .fcs_good(fcs_good), .len_good(len_good),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
      .rx_eof(rx_eof), .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok),
      .busy(busy));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do
      begin
         @(posedge clk);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   function automatic wfpf_crc_t crc_step(input wfpf_crc_t c,
                                          input logic [7:0] d);
      logic [7:0] f;
      f[0] = c[15] ^ d[0];
      for (int i = 1; i < 8; i++)
         f[i] = c[15-i] ^ f[i-1] ^ d[i];
      return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2],
              f[1] ^ f[3], f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6],
              f[5] ^ f[7], f[6], f[7]};
   endfunction

   function automatic wfpf_crc_t crc_frame();
      wfpf_crc_t c;
      c = 16'hffff;
      for (int p = OFS; p < FLEN; p++)
         if (p - OFS < 128 && MASK[p-OFS])
            c = crc_step(c, frame_bits[8*p +: 8]);
      return c;
   endfunction

   // One frame under a given setup; flags are checked, then cleared.
   task automatic run(input int kind, input logic [3:0] fa, input logic wen,
                      input logic fg, input logic lg, input logic bad,
                      input logic ew);
      int i;
      int hits;
      frame_bits[47:0] = DA[kind];
      bus(1'b1, `WFPF_OFS_CFGB, {16'h0, crc_frame() ^ {15'h0, bad}}, rd);
      bus(1'b1, `WFPF_OFS_CFGA, {16'h0, OFS, 4'h0, fa}, rd);
      bus(1'b1, `WFPF_OFS_WCS, {29'h0, 1'b1, 1'b0, wen}, rd);
      fcs_good <= fg;
      len_good <= lg;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      i = 0;
      hits = 0;
      while (busy !== 1'b1 && i < 4)
      begin
         @(posedge clk);
         i++;
      end
      while (busy !== 1'b0 && i < 400)
      begin
         @(posedge clk);
         i++;
      end
      repeat (6)
      begin
         @(posedge clk);
         hits += (wake_event === 1'b1);
      end
      chk("wake pulses", {31'h0, ew}, 32'(hits));
      bus(1'b0, `WFPF_OFS_WCS, 32'h0, rd);
      chk("wake status", {29'h0, 1'b1, ew, wen}, rd);
      bus(1'b0, `WFPF_OFS_CFGA, 32'h0, rd);
      chk("filter config", {16'h0, OFS, 3'h0, ew, fa}, rd);
      bus(1'b0, `WFPF_OFS_IRQ_FLAGS, 32'h0, rd);
      chk("irq flags", {23'h0, ew, 8'h0}, rd);
      chk("wol flag", {31'h0, ew}, {31'h0, wol_event_flag});
      bus(1'b1, `WFPF_OFS_WCS, 32'h2, rd);
      bus(1'b1, `WFPF_OFS_CFGA, {16'h0, OFS, 4'h1, fa}, rd);
      bus(1'b1, `WFPF_OFS_IRQ_FLAGS, 32'h100, rd);
      bus(1'b0, `WFPF_OFS_IRQ_FLAGS, 32'h0, rd);
      chk("irq flags cleared", 32'h0, rd);
   endtask

   initial
   begin
      {rst_b, soft_rst, go, fcs_good, len_good} = 5'h0;
      {avs_read, avs_write} = 2'h0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      cycles = 0;
      for (int p = 0; p < FLEN; p++)
         frame_bits[8*p +: 8] = 8'(p * 7 + 1);
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, `WFPF_OFS_CFGA, 32'h0, rd);
      chk("config reset", 32'h0, rd);
      bus(1'b1, `WFPF_OFS_CFGB, 32'hffffabcd, rd);
      bus(1'b0, `WFPF_OFS_CFGB, 32'h0, rd);
      chk("crc register", 32'h0000abcd, rd);
      bus(1'b1, 6'h30, 32'h5a5a5a5a, rd);
      bus(1'b0, 6'h30, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      for (int w = 0; w < 4; w++)
         bus(1'b1, `WFPF_OFS_MASK0 + 6'(4 * w), MASK[32*w +: 32], rd);
      bus(1'b1, `WFPF_OFS_ADDRA, 32'h1102, rd);
      bus(1'b1, `WFPF_OFS_ADDRB, 32'h3322, rd);
      bus(1'b1, `WFPF_OFS_ADDRC, 32'h5544, rd);
      bus(1'b1, `WFPF_OFS_IRQ_MASK, 32'h100, rd);
      bus(1'b0, `WFPF_OFS_IRQ_MASK, 32'h0, rd);
      chk("irq mask", 32'h00000100, rd);
      run(0, 4'h1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      run(0, 4'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      run(1, 4'h3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      run(0, 4'h3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      run(2, 4'h5, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      run(2, 4'h3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      run(2, 4'h1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      run(3, 4'h9, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      run(3, 4'h7, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      run(0, 4'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      run(0, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      run(0, 4'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      run(0, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      bus(1'b0, `WFPF_OFS_MASK3, 32'h0, rd);
      chk("mask after soft reset", 32'h80000000, rd);
      run(0, 4'h1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      print_verdict();
   end
endmodule
